/* File: core/lp_ctrl.sv */
// low-power wait/stop controller with bus pin hold and port control
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module lp_ctrl (
  // clock and reset
  input  wire logic                                     clock,
  input  wire logic                                     rst,
  // avalon-mm slave
  input  wire logic [lp_ctrl_pkg::addr_w-1:0]           avs_address,
  input  wire logic                                     avs_read,
  input  wire logic                                     avs_write,
  input  wire logic [lp_ctrl_pkg::data_w-1:0]           avs_writedata,
  input  wire logic [3:0]                               avs_byteenable,
  output logic      [lp_ctrl_pkg::data_w-1:0]           avs_readdata,
  output logic                                          avs_waitrequest,
  // cpu side
  input  wire logic                                     wait_insn,
  output logic                                          cpu_clk_en,
  output logic                                          osc_en,
  output logic                                          wake_pulse,
  // interrupt pins, asynchronous
  input  wire logic [lp_ctrl_pkg::n_irq-1:0]            irq_req,
  input  wire logic                                     nmi_n,
  // external bus engine, same clock
  input  wire lp_ctrl_pkg::pin_drive_t                  bus_drive,
  // bus/port pins
  input  wire logic [lp_ctrl_pkg::bus_w-1:0]            pin_i,
  output lp_ctrl_pkg::pin_drive_t                       pin_out
);

  localparam int unsigned BW = lp_ctrl_pkg::bus_w;
  localparam int unsigned NI = lp_ctrl_pkg::n_irq;
  localparam int unsigned PW = lp_ctrl_pkg::prio_w;

  typedef struct packed {
    lp_ctrl_pkg::lp_state_t   state;
    lp_ctrl_pkg::proc_mode_t  mode;
    lp_ctrl_pkg::wake_cause_t cause;
    logic                     stop_bit;
    logic [NI*PW-1:0]         prio;
    logic [BW-1:0]            port_out;
    logic [BW-1:0]            port_dir;
    lp_ctrl_pkg::pin_drive_t  pins;
    logic                     waitreq;
    logic [31:0]              rdata;
    logic                     clk_en;
    logic                     osc;
    logic                     wake;
  } ctrl_st_t;

  ctrl_st_t st_ff;
  ctrl_st_t nxt_st;

  // synchronised pins
  logic [NI-1:0] irq_s;
  logic          nmi_n_s;
  logic [BW-1:0] pin_s;

  lp_sync2 #(
    .W       (NI + 1),
    .RST_VAL ({{NI{1'b0}}, 1'b1})
  ) u_sync_evt (
    .clock (clock),
    .rst   (rst),
    .d     ({irq_req, nmi_n}),
    .q     ({irq_s, nmi_n_s})
  );

  lp_sync2 #(
    .W       (BW),
    .RST_VAL ('0)
  ) u_sync_pin (
    .clock (clock),
    .rst   (rst),
    .d     (pin_i),
    .q     (pin_s)
  );

  // merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // wake qualification
  logic [NI-1:0] irq_ok;
  logic          nmi_hit;
  logic          wake_cond;
  logic          low_power;
  logic          bus_mode;

  always_comb begin
    for (int i = 0; i < NI; i++) begin
      irq_ok[i] = irq_s[i] &&
                  (st_ff.prio[i*PW +: PW] != lp_ctrl_pkg::prio_off_lvl);
    end
  end

  assign nmi_hit   = !nmi_n_s;
  assign wake_cond = nmi_hit || (|irq_ok);
  assign low_power = (st_ff.state != lp_ctrl_pkg::st_run);
  assign bus_mode  = (st_ff.mode != lp_ctrl_pkg::pm_single);

  // bus request decode
  logic        req;
  logic        wr_commit;
  logic [31:0] wd_ctrl;
  logic [31:0] mrg_prio;
  logic [31:0] mrg_out;
  logic [31:0] mrg_dir;

  assign req       = avs_read || avs_write;
  assign wr_commit = avs_write && !st_ff.waitreq;

  always_comb begin
    nxt_st  = st_ff;
    wd_ctrl = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    mrg_prio = be_merge(32'(st_ff.prio), avs_writedata, avs_byteenable);
    mrg_out  = be_merge(32'(st_ff.port_out), avs_writedata, avs_byteenable);
    mrg_dir  = be_merge(32'(st_ff.port_dir), avs_writedata, avs_byteenable);
    nxt_st.wake = 1'b0;

    // handshake: one wait cycle, then one ready cycle
    nxt_st.waitreq = !(req && st_ff.waitreq);

    // read data captured while waitrequest is high
    if (avs_read && st_ff.waitreq) begin
      if (avs_address == lp_ctrl_pkg::ctrl_off) begin
        nxt_st.rdata = '0;
        nxt_st.rdata[lp_ctrl_pkg::ctrl_stop_bit] = st_ff.stop_bit;
        nxt_st.rdata[lp_ctrl_pkg::ctrl_mode_lsb +: 2] = st_ff.mode;
      end else if (avs_address == lp_ctrl_pkg::status_off) begin
        nxt_st.rdata = '0;
        nxt_st.rdata[lp_ctrl_pkg::stat_state_lsb +: 2] = st_ff.state;
        nxt_st.rdata[lp_ctrl_pkg::stat_cause_lsb +: 2] = st_ff.cause;
        nxt_st.rdata[lp_ctrl_pkg::stat_mode_lsb +: 2]  = st_ff.mode;
      end else if (avs_address == lp_ctrl_pkg::prio_off) begin
        nxt_st.rdata = 32'(st_ff.prio);
      end else if (avs_address == lp_ctrl_pkg::port_out_off) begin
        nxt_st.rdata = 32'(st_ff.port_out);
      end else if (avs_address == lp_ctrl_pkg::port_dir_off) begin
        nxt_st.rdata = 32'(st_ff.port_dir);
      end else if (avs_address == lp_ctrl_pkg::port_in_off) begin
        nxt_st.rdata = 32'(pin_s);
      end else begin
        nxt_st.rdata = '0;
      end
    end

    // low-power state machine
    case (st_ff.state)
      lp_ctrl_pkg::st_run: begin
        if (st_ff.stop_bit) begin
          nxt_st.state = lp_ctrl_pkg::st_stop;
        end else if (wait_insn) begin
          nxt_st.state = lp_ctrl_pkg::st_wait;
        end
      end
      lp_ctrl_pkg::st_wait, lp_ctrl_pkg::st_stop: begin
        if (wake_cond) begin
          nxt_st.state    = lp_ctrl_pkg::st_run;
          nxt_st.stop_bit = 1'b0;
          nxt_st.wake     = 1'b1;
          nxt_st.cause    = nmi_hit ? lp_ctrl_pkg::wk_nmi
                                    : lp_ctrl_pkg::wk_irq;
        end
      end
      default: begin
        nxt_st.state = lp_ctrl_pkg::st_run;
      end
    endcase

    // register writes; a software set of the stop bit wins over the wake clear
    if (wr_commit) begin
      if (avs_address == lp_ctrl_pkg::ctrl_off) begin
        if (avs_byteenable[0]) begin
          if (wd_ctrl[lp_ctrl_pkg::ctrl_stop_bit]) begin
            nxt_st.stop_bit = 1'b1;
          end
          if (wd_ctrl[lp_ctrl_pkg::ctrl_wait_bit] &&
              st_ff.state == lp_ctrl_pkg::st_run) begin
            nxt_st.state = lp_ctrl_pkg::st_wait;
          end
          if (wd_ctrl[lp_ctrl_pkg::ctrl_mode_lsb +: 2] != 2'b11) begin
            nxt_st.mode = lp_ctrl_pkg::proc_mode_t'(
                            wd_ctrl[lp_ctrl_pkg::ctrl_mode_lsb +: 2]);
          end
        end
      end else if (avs_address == lp_ctrl_pkg::prio_off) begin
        nxt_st.prio = mrg_prio[NI*PW-1:0];
      end else if (avs_address == lp_ctrl_pkg::port_out_off) begin
        if (!bus_mode) begin
          nxt_st.port_out = mrg_out[BW-1:0];
        end
      end else if (avs_address == lp_ctrl_pkg::port_dir_off) begin
        if (!bus_mode) begin
          nxt_st.port_dir = mrg_dir[BW-1:0];
        end
      end
    end

    // pin drive: bus frozen in low power, ports in single-chip mode
    if (!bus_mode) begin
      nxt_st.pins.level  = st_ff.port_out;
      nxt_st.pins.enable = st_ff.port_dir;
    end else if (!low_power) begin
      nxt_st.pins = bus_drive;
    end else begin
      nxt_st.pins = st_ff.pins;
    end

    // clock gating follows the next state
    nxt_st.clk_en = (nxt_st.state == lp_ctrl_pkg::st_run);
    nxt_st.osc    = (nxt_st.state != lp_ctrl_pkg::st_stop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff.state    <= lp_ctrl_pkg::st_run;
      st_ff.mode     <= lp_ctrl_pkg::mode_rst;
      st_ff.cause    <= lp_ctrl_pkg::wk_reset;
      st_ff.stop_bit <= 1'b0;
      st_ff.prio     <= lp_ctrl_pkg::prio_rst;
      st_ff.port_out <= lp_ctrl_pkg::port_rst;
      st_ff.port_dir <= lp_ctrl_pkg::port_rst;
      st_ff.pins     <= '0;
      st_ff.waitreq  <= 1'b1;
      st_ff.rdata    <= '0;
      st_ff.clk_en   <= 1'b1;
      st_ff.osc      <= 1'b1;
      st_ff.wake     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign cpu_clk_en      = st_ff.clk_en;
  assign osc_en          = st_ff.osc;
  assign wake_pulse      = st_ff.wake;
  assign pin_out         = st_ff.pins;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence ack_seq;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence resume_seq;
    st_ff.state == lp_ctrl_pkg::st_run && wake_pulse && cpu_clk_en;
  endsequence

  stay_asleep_a: assert property (
    (low_power && !wake_cond && !$past(wr_commit)) |=>
      st_ff.state == $past(st_ff.state) && !wake_pulse)
    else $error("low power left without a wake source");

  wake_resume_a: assert property (
    (low_power && wake_cond) |=> resume_seq ##1 !wake_pulse)
    else $error("accepted wake did not resume running");

  nmi_wakes_a: assert property (
    (low_power && nmi_hit) |=>
      st_ff.cause == lp_ctrl_pkg::wk_nmi && osc_en)
    else $error("non-maskable wake missed");

  zero_prio_a: assert property (
    (low_power && nmi_n_s && irq_ok == '0) |=> low_power)
    else $error("zero priority interrupt woke the chip");

  wait_hold_a: assert property (
    (st_ff.state == lp_ctrl_pkg::st_wait && bus_mode) |=> $stable(pin_out))
    else $error("bus pins moved in wait");

  stop_hold_a: assert property (
    (st_ff.state == lp_ctrl_pkg::st_stop && bus_mode) |=>
      $stable(pin_out) && (osc_en == $past(wake_cond)))
    else $error("bus pins moved in stop");

  single_port_a: assert property (
    !bus_mode |=> pin_out.level == $past(st_ff.port_out) &&
                  pin_out.enable == $past(st_ff.port_dir))
    else $error("port pins not driven from port registers");

  port_lock_a: assert property (
    (wr_commit && bus_mode &&
     (avs_address == lp_ctrl_pkg::port_out_off ||
      avs_address == lp_ctrl_pkg::port_dir_off)) |=>
      $stable(st_ff.port_out) && $stable(st_ff.port_dir))
    else $error("port write took effect in bus mode");

  bus_ack_a: assert property (
    (req && avs_waitrequest) |=> ack_seq)
    else $error("bus answer not given after one wait cycle");

endmodule

/* File: common/lp_ctrl_pkg.sv */
// shared constants and types for the low-power wait/stop controller
package lp_ctrl_pkg;

  // sizes
  localparam int unsigned bus_w   = 16;
  localparam int unsigned n_irq   = 4;
  localparam int unsigned prio_w  = 3;
  localparam int unsigned addr_w  = 5;
  localparam int unsigned data_w  = 32;

  // register byte offsets
  localparam logic [addr_w-1:0] ctrl_off     = 5'h00;
  localparam logic [addr_w-1:0] status_off   = 5'h04;
  localparam logic [addr_w-1:0] prio_off     = 5'h08;
  localparam logic [addr_w-1:0] port_out_off = 5'h0c;
  localparam logic [addr_w-1:0] port_dir_off = 5'h10;
  localparam logic [addr_w-1:0] port_in_off  = 5'h14;

  // control register fields
  localparam int unsigned ctrl_wait_bit = 0;
  localparam int unsigned ctrl_stop_bit = 1;
  localparam int unsigned ctrl_mode_lsb = 2;

  // status register fields
  localparam int unsigned stat_state_lsb = 0;
  localparam int unsigned stat_cause_lsb = 2;
  localparam int unsigned stat_mode_lsb  = 4;

  typedef enum logic [1:0] {
    pm_single = 2'b00,
    pm_expand = 2'b01,
    pm_micro  = 2'b10
  } proc_mode_t;

  typedef enum logic [1:0] {
    st_run  = 2'b00,
    st_wait = 2'b01,
    st_stop = 2'b10
  } lp_state_t;

  typedef enum logic [1:0] {
    wk_reset = 2'b00,
    wk_nmi   = 2'b01,
    wk_irq   = 2'b10
  } wake_cause_t;

  // reset values
  localparam proc_mode_t          mode_rst = pm_single;
  localparam logic [bus_w-1:0]    port_rst = 16'h0000;
  localparam logic [n_irq*prio_w-1:0] prio_rst = 12'h000;
  localparam logic [prio_w-1:0]   prio_off_lvl = 3'h0;

  // pin drive carrier
  typedef struct packed {
    logic [bus_w-1:0] level;
    logic [bus_w-1:0] enable;
  } pin_drive_t;

endpackage

/* File: core/lp_sync2.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module lp_sync2 #(
  parameter int unsigned       W       = 1,
  parameter logic [W-1:0]      RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = d;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.sync;

endmodule

/* File: tb/lp_far_side.sv */
// far-side model: interrupt sources and external bus engine
`timescale 1ns/100ps
module lp_far_side (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // commands from the bench
  input  wire logic [3:0]        irq_set,
  input  wire logic              nmi_set,
  input  wire logic              bus_hold,
  input  wire logic              slow,
  // toward the controller
  output logic [3:0]             irq_req,
  output logic                   nmi_n,
  output lp_ctrl_pkg::pin_drive_t bus_drive
);
  logic [3:0]  irq_dly_ff;
  logic        nmi_dly_ff;
  logic [31:0] lfsr_ff;

  // slow sources answer one cycle later than prompt ones
  always_ff @(posedge clock) begin
    irq_dly_ff <= irq_set;
    nmi_dly_ff <= nmi_set;
    irq_req    <= slow ? irq_dly_ff : irq_set;
    nmi_n      <= ~(slow ? nmi_dly_ff : nmi_set);
    if (rst)
      lfsr_ff <= 32'h1234abcd;
    else if (!bus_hold)
      lfsr_ff <= {lfsr_ff[30:0], ^(lfsr_ff & 32'h80200003)};
  end

  // bus engine changes its drive every cycle unless held
  assign bus_drive = lfsr_ff;
endmodule

/* File: tb/low_power_wait_stop_control_tb.sv */
// testbench for the low-power wait/stop controller
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module low_power_wait_stop_control_tb;
  logic                           clock = 0;
  logic                           rst = 1;
  logic [lp_ctrl_pkg::addr_w-1:0] avs_address = '0;
  logic                           avs_read = 0;
  logic                           avs_write = 0;
  logic [31:0]                    avs_writedata = '0;
  logic [31:0]                    avs_readdata;
  logic [31:0]                    rd;
  logic                           avs_waitrequest;
  logic                           wait_insn = 0;
  logic                           cpu_clk_en;
  logic                           osc_en;
  logic                           wake_pulse;
  logic [3:0]                     irq_req;
  logic [3:0]                     irq_set = '0;
  logic                           nmi_n;
  logic                           nmi_set = 0;
  logic                           bus_hold = 0;
  logic                           slow = 0;
  lp_ctrl_pkg::pin_drive_t        bus_drive;
  lp_ctrl_pkg::pin_drive_t        pin_out;
  lp_ctrl_pkg::pin_drive_t        frz;
  logic [15:0]                    pin_i = 16'h0000;
  logic [15:0]                    m_out;
  logic [15:0]                    m_dir;
  logic [31:0]                    seed = 32'hc164f8bd;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int m_state = 0;
  int m_cause = 0;
  int m_mode = 0;

  always #5 clock = ~clock;

  lp_ctrl lp_ctrl_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wait_insn(wait_insn), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
    .wake_pulse(wake_pulse), .irq_req(irq_req), .nmi_n(nmi_n),
    .bus_drive(bus_drive), .pin_i(pin_i), .pin_out(pin_out));

  lp_far_side lp_far_side_inst (.clock(clock), .rst(rst), .irq_set(irq_set),
    .nmi_set(nmi_set), .bus_hold(bus_hold), .slow(slow),
    .irq_req(irq_req), .nmi_n(nmi_n), .bus_drive(bus_drive));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] stat();
    return 32'(m_state | (m_cause << 2) | (m_mode << 4));
  endfunction

  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    `CHK(n, 2)
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clock);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK(rd, e)
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    `CHK({cpu_clk_en, osc_en, pin_out}, {2'b11, 32'h0})
    rchk(lp_ctrl_pkg::status_off, stat());
    rchk(5'h18, 32'h0);
    pin_i <= xs();
    m_out = xs();
    m_dir = xs();
    bus(1, lp_ctrl_pkg::port_out_off, {16'h0, m_out});
    bus(1, lp_ctrl_pkg::port_dir_off, {16'h0, m_dir});
    @(posedge clock);
    `CHK(pin_out, {m_out, m_dir})
    rchk(lp_ctrl_pkg::port_in_off, {16'h0, pin_i});
    for (int md = 1; md < 3; md++) begin
      slow <= (md == 2);
      bus(1, lp_ctrl_pkg::ctrl_off, md << 2);
      m_mode = md;
      bus(1, lp_ctrl_pkg::port_out_off, {16'h0, ~m_out});
      rchk(lp_ctrl_pkg::port_out_off, {16'h0, m_out});
      // irq1 at level 3 may wake in wait; stop runs with all levels 0, so only nmi wakes
      bus(1, lp_ctrl_pkg::prio_off,
          md == 1 ? 32'h18 : 32'h0);
      for (int i = 0; i < 3; i++) begin
        frz = bus_drive;
        @(posedge clock);
        `CHK(pin_out, frz)
      end
      bus_hold <= 1;
      @(posedge clock);
      frz = bus_drive;
      bus(1, lp_ctrl_pkg::ctrl_off, (md << 2) | md);
      m_state = md;
      rchk(lp_ctrl_pkg::status_off, stat());
      bus_hold <= 0;
      irq_set <= (md == 1) ? 4'b0001 : 4'b1111;
      for (int i = 0; i < 10; i++) begin
        @(posedge clock);
        `CHK({pin_out, cpu_clk_en, osc_en}, {frz, 1'b0, md == 1})
        `CHK(wake_pulse, 1'b0)
      end
      if (md == 1)
        irq_set <= 4'b0011;
      else
        nmi_set <= 1;
      n = 0;
      while (wake_pulse !== 1'b1 && n < 8) begin
        @(posedge clock);
        n++;
      end
      `CHK(wake_pulse, 1'b1)
      irq_set <= '0;
      nmi_set <= 0;
      @(posedge clock);
      `CHK({cpu_clk_en, osc_en}, 2'b11)
      m_state = 0;
      m_cause = (md == 1) ? 2 : 1;
      rchk(lp_ctrl_pkg::status_off, stat());
      rchk(lp_ctrl_pkg::ctrl_off, md << 2);
    end
    bus(1, lp_ctrl_pkg::ctrl_off, 32'h0);
    // mode code 3 is ignored
    bus(1, lp_ctrl_pkg::ctrl_off, 32'hc);
    rchk(lp_ctrl_pkg::ctrl_off, 32'h0);
    m_mode = 0;
    m_out = xs();
    bus(1, lp_ctrl_pkg::port_out_off, {16'h0, m_out});
    @(posedge clock);
    `CHK(pin_out, {m_out, m_dir})
    wait_insn <= 1;
    @(posedge clock);
    wait_insn <= 0;
    repeat (2) @(posedge clock);
    `CHK(cpu_clk_en, 1'b0)
    m_state = 1;
    rchk(lp_ctrl_pkg::status_off, stat());
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    m_state = 0;
    m_cause = 0;
    `CHK({cpu_clk_en, pin_out}, {1'b1, 32'h0})
    rchk(lp_ctrl_pkg::status_off, stat());
    summarize();
  end
endmodule
